// ===== hw/ee_consts.svh
// register offsets, field positions, reset values and timing counts of the front end
`ifndef EE_CONSTS_SVH
`define EE_CONSTS_SVH

`define EE_OFF_CTRL       12'h000
`define EE_OFF_STATUS     12'h004
`define EE_OFF_CAPTURE    12'h008

`define EE_CTRL_EN_BIT    0
`define EE_CTRL_RESET     32'h0000_0001

`define EE_CAP_ADDR_LSB   0
`define EE_CAP_DATA_LSB   8
`define EE_CAP_WADDR_LSB  16

`define EE_TYPE_ARRAY     4'ha
`define EE_TYPE_WPREG     4'h6

`define EE_CLK_PERIOD_NS  10
`define EE_TWR_MS         5
`define EE_TWR_CYCLES     ((`EE_TWR_MS * 1000000) / `EE_CLK_PERIOD_NS)

`endif

// ===== hw/ee_front_end.sv
// two-wire serial slave front end of a 256-byte eeprom with an apb register port
//
// What this block does
// - storage is 16 pages of 16 bytes, chosen by an 8-bit word address
// - data changes only while clock low; changes while high are start or stop
// - falling data while clock high is a start, which begins every command
// - rising data while clock high is a stop; stop after a read means standby
// - words are 8 bits; device pulls data low on ninth clock to acknowledge
// - standby at power-up, and after stop once internal operation has finished
// - top nibble 1010 selects the array, 0110 the write-protect register
// - next three bits must match the three select pins for selection
// - eighth address bit high means read, low means write
// - on a match acknowledge low; on mismatch stay silent, back to standby
// - once write-protect is programmed, never acknowledge a 0110 address word
// - internal write runs from stop ending a write, at most 5 ms
// - sample incoming bits on rising clock, shift outgoing on falling clock
// - data line is open drain: pulled low or released, never driven high
// - during the internal write cycle inputs are ignored, bus gets no answer
`include "ee_consts.svh"

module ee_front_end #(
   parameter int TWR_CYCLES = `EE_TWR_CYCLES
) (
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // two-wire link
   input  wire logic        scl,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   // hard-wired select pins
   input  wire logic        select_pin_high,
   input  wire logic        select_pin_mid,
   input  wire logic        select_pin_low,
   // device status
   output ee_pkg::ee_status_t dev_status
);
   import ee_pkg::*;

   localparam int TW = $clog2(TWR_CYCLES + 1);

   // link domain: the bit on the data line at each rising serial clock
   logic             link_bit;

   // synchronisers into pclk
   logic [1:0]       scl_sync;
   logic [1:0]       sda_sync;
   logic [1:0]       bit_sync;
   logic [1:0]       pin_sync [3];
   logic             scl_d1;
   logic             scl_d2;
   logic             sda_d1;

   ee_state_t        state;
   ee_state_t        ack_next;
   logic [3:0]       bit_cnt;
   logic [7:0]       shreg;
   ee_addr_t         addr_word;
   logic [7:0]       last_byte;
   ee_waddr_t        word_addr;
   logic             have_waddr;
   logic             got_data;
   logic             ack_on;
   logic             wp_prog;
   logic             enable;
   logic [TW-1:0]    twr_cnt;

   always_ff @(posedge scl or negedge presetn)
   begin
      if (!presetn)
         link_bit <= 1'b1;
      else
         link_bit <= sda_in;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         bit_sync <= 2'h3;
         scl_d1   <= 1'b1;
         scl_d2   <= 1'b1;
         sda_d1   <= 1'b1;
      end
      else
      begin
         scl_sync <= {scl_sync[0], scl};
         sda_sync <= {sda_sync[0], sda_in};
         bit_sync <= {bit_sync[0], link_bit};
         scl_d1   <= scl_sync[1];
         scl_d2   <= scl_d1;
         sda_d1   <= sda_sync[1];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_sync[0] <= 2'h0;
         pin_sync[1] <= 2'h0;
         pin_sync[2] <= 2'h0;
      end
      else
      begin
         pin_sync[0] <= {pin_sync[0][0], select_pin_low};
         pin_sync[1] <= {pin_sync[1][0], select_pin_mid};
         pin_sync[2] <= {pin_sync[2][0], select_pin_high};
      end
   end

   wire logic [2:0] sel_pins = {pin_sync[2][1], pin_sync[1][1], pin_sync[0][1]};

   // data change while clock high marks start or stop
   wire logic start_ev = scl_sync[1] && scl_d1 && sda_d1 && !sda_sync[1];
   wire logic stop_ev  = scl_sync[1] && scl_d1 && !sda_d1 && sda_sync[1];
   // the rise is acted on one cycle late so that the captured bit has settled
   wire logic scl_rise = scl_d1 && !scl_d2;
   wire logic scl_fall = !scl_sync[1] && scl_d1;
   wire logic [7:0] next_shreg = {shreg[6:0], bit_sync[1]};
   wire logic byte_done = scl_rise && (bit_cnt == 4'h7);

   function automatic logic addr_match(input ee_addr_t w, input logic [2:0] pins,
                                       input logic wp_done);
      logic type_ok;
      // type code, 0110 refused once locked
      type_ok = (w.dev_type == `EE_TYPE_ARRAY) ||
                ((w.dev_type == `EE_TYPE_WPREG) && !wp_done);
      // all three select bits must match the pins
      return type_ok && (w.sel == pins);
   endfunction

   wire ee_addr_t rx_word  = ee_addr_t'(next_shreg);
   wire logic     rx_match = addr_match(rx_word, sel_pins, wp_prog);
   wire logic     wr_end   = (state == ST_WDATA) && got_data;

   ee_state_t     next_state;

   always_comb
   begin
      next_state = state;
      if (state == ST_BUSY)
      begin
         // nothing on the bus is seen while writing
         if (twr_cnt == '0)
            next_state = ST_STANDBY;
      end
      else if (start_ev && enable)
         // start begins address reception, even mid-transfer
         next_state = ST_ADDR;
      else if (stop_ev)
         // stop ends a read, or after data starts the write
         next_state = wr_end ? ST_BUSY : ST_STANDBY;
      else
      begin
         unique case (state)
            ST_STANDBY : next_state = ST_STANDBY;
            // silent return to standby on a mismatch
            ST_ADDR    : if (byte_done) next_state = rx_match ? ST_ACK : ST_STANDBY;
            ST_ACK     : if (scl_fall && ack_on) next_state = ack_next;
            ST_WDATA   : if (byte_done) next_state = ST_ACK;
            ST_READ    : next_state = ST_READ;
            ST_BUSY    : next_state = ST_BUSY;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state   <= ST_STANDBY;
         twr_cnt <= '0;
      end
      else
      begin
         state <= next_state;
         if (next_state == ST_BUSY && state != ST_BUSY)
            twr_cnt <= TW'(TWR_CYCLES - 1);
         else if (twr_cnt != '0)
            twr_cnt <= twr_cnt - 1'b1;
      end
   end

   // eight-bit words shifted in, counted from each start
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bit_cnt <= 4'h0;
         shreg   <= 8'h00;
      end
      else if (start_ev && enable && state != ST_BUSY)
         bit_cnt <= 4'h0;
      else if (scl_rise && (state == ST_ADDR || state == ST_WDATA))
      begin
         shreg   <= next_shreg;
         bit_cnt <= byte_done ? 4'h0 : bit_cnt + 4'h1;
      end
   end

   // address word captured right after the start
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         addr_word  <= '0;
         ack_next   <= ST_STANDBY;
         have_waddr <= 1'b0;
         got_data   <= 1'b0;
         last_byte  <= 8'h00;
         word_addr  <= '0;
      end
      else if (state == ST_ADDR && byte_done)
      begin
         addr_word  <= rx_word;
         ack_next   <= rx_word.rd ? ST_READ : ST_WDATA;
         have_waddr <= 1'b0;
         got_data   <= 1'b0;
      end
      else if (state == ST_WDATA && byte_done)
      begin
         last_byte <= next_shreg;
         if (!have_waddr)
         begin
            // 8-bit word address, page and byte within page
            word_addr  <= ee_waddr_t'(next_shreg);
            have_waddr <= 1'b1;
         end
         else
         begin
            got_data <= 1'b1;
            if (got_data)
               // only the byte offset advances, so the page wraps on itself
               word_addr.offs <= word_addr.offs + 4'h1;
         end
      end
   end

   // acknowledge held low for the whole ninth clock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sda_oe <= 1'b0;
         ack_on <= 1'b0;
      end
      else if (state != ST_ACK || start_ev || stop_ev)
      begin
         // released whenever no acknowledge is due
         sda_oe <= 1'b0;
         ack_on <= 1'b0;
      end
      else if (scl_fall)
      begin
         // driven changes follow the falling clock
         sda_oe <= !ack_on;
         ack_on <= !ack_on;
      end
   end

   // open drain: the only level ever driven is low
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sda_out <= 1'b0;
      else
         sda_out <= 1'b0;
   end

   // write-protect register programmed by a finished 0110 write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wp_prog <= 1'b0;
      else if (stop_ev && wr_end && addr_word.dev_type == `EE_TYPE_WPREG)
         wp_prog <= 1'b1;
   end

   // standby from reset and after the write cycle ends
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dev_status <= '{rd: 1'b0, wp_prog: 1'b0, busy: 1'b0, standby: 1'b1};
      else
         dev_status <= '{rd: addr_word.rd, wp_prog: wp_prog,
                         busy: next_state == ST_BUSY,
                         standby: next_state == ST_STANDBY};
   end

   // apb slave: one wait state, unmapped addresses answer with pslverr
   wire logic apb_acc  = psel && penable && !pready;
   wire logic hit_ctrl = paddr == `EE_OFF_CTRL;
   wire logic hit_stat = paddr == `EE_OFF_STATUS;
   wire logic hit_cap  = paddr == `EE_OFF_CAPTURE;
   wire logic hit_any  = hit_ctrl || hit_stat || hit_cap;
   wire logic [31:0] cap_word = (32'(addr_word) << `EE_CAP_ADDR_LSB) |
                                (32'(last_byte) << `EE_CAP_DATA_LSB) |
                                (32'(word_addr) << `EE_CAP_WADDR_LSB);
   wire logic [31:0] rd_mux = hit_ctrl ? {31'h0, enable} :
                              hit_stat ? 32'(dev_status) :
                              hit_cap  ? cap_word : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         enable  <= 1'(`EE_CTRL_RESET >> `EE_CTRL_EN_BIT);
      end
      else
      begin
         pready  <= apb_acc;
         pslverr <= apb_acc && !hit_any;
         prdata  <= (apb_acc && !pwrite) ? rd_mux : 32'h0000_0000;
         if (apb_acc && pwrite && hit_ctrl)
            enable <= pwdata[`EE_CTRL_EN_BIT];
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   busy_no_ack_a : assert property (state == ST_BUSY |-> !sda_oe)
      else $error("data line driven during write cycle");
   start_restart_a : assert property (start_ev && enable && state != ST_BUSY
      |=> state == ST_ADDR && bit_cnt == 4'h0)
      else $error("start did not restart address reception");
   read_stop_a : assert property (stop_ev && state == ST_READ |=> state == ST_STANDBY)
      else $error("stop after read did not enter standby");
   mismatch_quiet_a : assert property (state == ST_ADDR && byte_done && !start_ev
      && !stop_ev && rx_word.sel != sel_pins |=> state == ST_STANDBY ##1 !sda_oe)
      else $error("mismatched address word not ignored");
   wp_nack_a : assert property (state == ST_ADDR && byte_done && wp_prog && !start_ev
      && !stop_ev && rx_word.dev_type == `EE_TYPE_WPREG |=> state != ST_ACK)
      else $error("0110 word acknowledged after protection");
   oe_in_ack_a : assert property (sda_oe |-> state == ST_ACK && ack_on)
      else $error("data line pulled outside acknowledge");
   twr_load_a : assert property (state == ST_BUSY && $past(state) != ST_BUSY
      |-> twr_cnt == TW'(TWR_CYCLES - 1))
      else $error("write cycle length wrong");
   busy_end_a : assert property (state == ST_BUSY && twr_cnt == '0
      |=> state == ST_STANDBY && dev_status.standby)
      else $error("standby not entered after write cycle");
   ack_fall_a : assert property ($rose(sda_oe) |-> $past(scl_fall))
      else $error("acknowledge not launched on falling clock");

   ack_given_c : cover property (state == ST_ADDR ##1 state == ST_ACK ##[1:300] sda_oe);
   write_cycle_c : cover property (state == ST_WDATA ##1 state == ST_BUSY);
   wp_set_c : cover property ($rose(wp_prog));
   read_end_c : cover property (state == ST_READ ##1 state == ST_STANDBY);

endmodule

// ===== hw/ee_pkg.sv
// types shared by the two-wire eeprom front end
package ee_pkg;

   typedef enum logic [2:0] {
      ST_STANDBY,
      ST_ADDR,
      ST_ACK,
      ST_WDATA,
      ST_READ,
      ST_BUSY
   } ee_state_t;

   // device address word as it arrives, msb first
   typedef struct packed {
      logic [3:0] dev_type;
      logic [2:0] sel;
      logic       rd;
   } ee_addr_t;

   // 256 bytes as 16 pages of 16 bytes
   typedef struct packed {
      logic [3:0] page;
      logic [3:0] offs;
   } ee_waddr_t;

   typedef struct packed {
      logic rd;
      logic wp_prog;
      logic busy;
      logic standby;
   } ee_status_t;

endpackage

// ===== tb/ee_front_end_tb_top.sv
// self-checking bench of the two-wire eeprom front end
module ee_front_end_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import ee_pkg::*;

   logic               pclk = 1'b0;
   logic               lclk = 1'b0;
   logic               presetn = 1'b0;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite = 1'b0;
   logic [11:0]        paddr = 12'h000;
   logic [31:0]        pwdata = 32'h0;
   logic               pready;
   logic [31:0]        prdata;
   logic               pslverr;
   logic               scl;
   logic               sda_drv;
   logic               sda_in;
   logic               sda_out;
   logic               sda_oe;
   logic [2:0]         sel_pins = 3'h5;
   ee_status_t         dev_status;
   int                 mismatches = 0;
   int                 checked = 0;
   int                 busy_run = 0;
   int                 busy_len = 0;
   localparam int      INTERNAL_WRITE_CYCLE_TIME = 200;
   logic               ack;
   logic               e;
   logic [31:0]        q;
   typedef struct packed {logic [7:0] aw; logic ok;} ee_row_t;
   ee_row_t            rows [8];

   always #5 pclk = ~pclk;
   // odd half period keeps the link clock unrelated in phase
   always #7.5 lclk = ~lclk;
   // pull-up on the wired data line
   assign sda_in = sda_drv & !(sda_oe && !sda_out);

   ee_front_end #(.TWR_CYCLES(INTERNAL_WRITE_CYCLE_TIME)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
      .sda_oe(sda_oe), .select_pin_high(sel_pins[2]), .select_pin_mid(sel_pins[1]),
      .select_pin_low(sel_pins[0]), .dev_status(dev_status));

   ee_host_model host (.lclk(lclk), .sda_line(sda_in), .scl(scl), .sda_drv(sda_drv));

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one wait state: pready is sampled high at the second access edge
      chk(n, 2, "apb wait states");
   endtask

   // length of the last busy run in pclk cycles; a run that overlaps a poll is still whole
   always @(posedge pclk)
   begin
      if (dev_status.busy === 1'b1)
      begin
         busy_run <= busy_run + 1;
         busy_len <= 0;
      end
      else if (busy_run != 0)
      begin
         busy_len <= busy_run;
         busy_run <= 0;
      end
   end

   // busy lasts exactly the write cycle count
   task automatic wait_idle();
      while (dev_status.busy !== 1'b0)
         @(posedge pclk);
      repeat (2) @(posedge pclk);
      chk(busy_len, INTERNAL_WRITE_CYCLE_TIME, "write cycle length");
   endtask

   initial
   begin
      #400us;
      mismatches++;
      finish_test();
   end

   initial
   begin
      rows = '{'{8'haa, 1'b1}, '{8'hab, 1'b1}, '{8'ha2, 1'b0}, '{8'ha8, 1'b0},
               '{8'hae, 1'b0}, '{8'h2a, 1'b0}, '{8'h5a, 1'b0}, '{8'h6a, 1'b1}};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      chk(dev_status, 4'h1, "reset status");
      chk(sda_oe, 0, "reset sda_oe");
      apb(0, 12'h000, 0);
      chk(q, 1, "ctrl reset");
      apb(0, 12'h00c, 0);
      chk(e, 1, "unmapped error");
      chk(q, 0, "unmapped data");
      foreach (rows[i])
      begin
         host.start();
         host.send(rows[i].aw, 8, ack);
         chk(ack, rows[i].ok, "address ack");
         host.stop();
         repeat (10) @(posedge pclk);
         chk({dev_status.busy, dev_status.standby}, 2'b01, "standby");
         chk({sda_oe, sda_out}, 0, "line released");
      end
      host.recover();
      host.send(8'h55, 4, ack);
      host.start();
      host.send(8'haa, 8, ack);
      chk(ack, 1, "restart address");
      host.stop();
      host.start();
      host.send(8'haa, 8, ack);
      host.send(8'h35, 8, e);
      chk({ack, e}, 2'b11, "word address ack");
      host.send(8'h5c, 8, ack);
      chk(ack, 1, "data ack");
      host.stop();
      chk(dev_status.busy, 1, "write cycle");
      host.start();
      host.send(8'haa, 8, ack);
      chk(ack, 0, "busy poll");
      host.stop();
      wait_idle();
      apb(0, 12'h008, 0);
      chk(q[15:8], 8'h5c, "data byte");
      chk(q[23:20], 4'h3, "page");
      host.start();
      host.send(8'h6a, 8, ack);
      host.send(8'h00, 8, ack);
      host.send(8'h00, 8, ack);
      host.stop();
      chk(dev_status.busy, 1, "wp write cycle");
      wait_idle();
      chk(dev_status.wp_prog, 1, "wp set");
      host.start();
      host.send(8'h6a, 8, ack);
      chk(ack, 0, "wp locked");
      host.stop();
      apb(1, 12'h000, 0);
      host.start();
      host.send(8'haa, 8, ack);
      chk(ack, 0, "disabled");
      host.stop();
      apb(1, 12'h000, 1);
      apb(0, 12'h004, 0);
      chk(q[2:0], 3'h5, "status");
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(dev_status, 4'h1, "second reset");
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(dev_status, 4'h1, "standby after release");
      chk(sda_oe, 0, "released after reset");
      apb(0, 12'h000, 0);
      chk(q, 1, "ctrl after reset");
      finish_test();
   end
endmodule

// ===== tb/ee_host_model.sv
// two-wire bus host model that makes clock and data from its own link clock
module ee_host_model (
   // link clock
   input  wire logic lclk,
   // wire level and host drivers
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_drv
);
   timeunit 1ns;
   timeprecision 100ps;

   // clock stands high and data released outside frames
   initial
   begin
      scl <= 1'b1;
      sda_drv <= 1'b1;
   end

   task automatic bit_out(input logic b, output logic s);
      scl <= 1'b0;
      repeat (4) @(posedge lclk);
      sda_drv <= b;
      repeat (4) @(posedge lclk);
      scl <= 1'b1;
      repeat (6) @(posedge lclk);
      s = sda_line;
      repeat (2) @(posedge lclk);
   endtask

   task automatic start();
      scl <= 1'b0;
      repeat (4) @(posedge lclk);
      sda_drv <= 1'b1;
      repeat (4) @(posedge lclk);
      scl <= 1'b1;
      repeat (4) @(posedge lclk);
      sda_drv <= 1'b0;
      repeat (4) @(posedge lclk);
   endtask

   task automatic stop();
      scl <= 1'b0;
      repeat (4) @(posedge lclk);
      sda_drv <= 1'b0;
      repeat (4) @(posedge lclk);
      scl <= 1'b1;
      repeat (4) @(posedge lclk);
      sda_drv <= 1'b1;
      repeat (8) @(posedge lclk);
   endtask

   // word msb first, ninth clock released for ack
   task automatic send(input logic [7:0] w, input int n, output logic ack);
      logic s;
      for (int i = 7; i > 7 - n; i--)
         bit_out(w[i], s);
      s = 1'b1;
      if (n == 8)
         bit_out(1'b1, s);
      ack = !s;
   endtask

   // up to nine clocks looking for data high, then a start
   task automatic recover();
      logic s;
      s = 1'b0;
      for (int i = 0; i < 9 && !s; i++)
         bit_out(1'b1, s);
      start();
   endtask
endmodule
